// file: hdl/mrs_pkg.sv
package mrs_pkg;
  // Serial timing at the unit clock
  localparam int unsigned CLK_HZ = 40000000;
  localparam int unsigned BAUD = 9600;
  localparam int unsigned BITS_PER_BYTE = 10;
  localparam int unsigned CYC_PER_BYTE = (CLK_HZ * BITS_PER_BYTE) / BAUD;
  // Response time is 2.5 byte periods, kept in tenths
  localparam int unsigned RESP_TENTHS = 25;
  localparam int unsigned RESP_CYC = (CYC_PER_BYTE * RESP_TENTHS) / 10;
  localparam int unsigned JITTER_CYC_DEF = 4167;
  localparam int unsigned REPLY_BYTES_DEF = 7;
  localparam int unsigned GUARD_BYTES = 5;
  localparam int unsigned GUARD_CYC = CYC_PER_BYTE * GUARD_BYTES;
  localparam logic [7:0] ADDR_MAX = 8'hfe;
  localparam logic [7:0] BCAST_ADDR_DEF = 8'hff;
  localparam logic [7:0] ATTN_ACK = 8'h06;
  localparam logic [7:0] ATTN_NAK = 8'h15;
  localparam int unsigned CNT_W = 32;

  typedef enum logic [1:0] {
    MRS_LINK_RS232,
    MRS_LINK_USB,
    MRS_LINK_RS485_4W,
    MRS_LINK_RS485_2W
  } mrs_link_e;

  typedef struct packed {
    logic [7:0] addr;
    logic ok;
  } mrs_cmd_s;

  typedef struct packed {
    logic go;
    logic [7:0] attn;
  } mrs_reply_s;
endpackage : mrs_pkg

// file: hdl/mrs_delay_timer.sv
`timescale 1ns/1ps
// Down counter, loaded with a cycle count, pulses done when it expires
module mrs_delay_timer #(
  parameter int unsigned W = 32
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic clk_en,
  // Control
  input wire logic load,
  input wire logic [W-1:0] count,
  input wire logic abort,
  // Status
  output logic busy_q,
  output logic done_q
);
  logic [W-1:0] cnt_q;

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cnt_q <= '0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end
    else if (clk_en)
    begin
      done_q <= 1'b0;
      if (abort)
      begin
        busy_q <= 1'b0;
      end
      else if (load)
      begin
        // A zero count fires at once, so no wait is added
        cnt_q <= count;
        busy_q <= (count != '0);
        done_q <= (count == '0);
      end
      else if (busy_q)
      begin
        cnt_q <= cnt_q - 1'b1;
        if (cnt_q == {{(W-1){1'b0}}, 1'b1})
        begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end
      end
    end
  end
endmodule : mrs_delay_timer

// file: hdl/mrs_scheduler.sv
`timescale 1ns/1ps
// Overview of operation
// - RS232/USB: single host, no address filter
// - Multidrop links use the unit's own address
// - Matching unit replies at once, others silent
// - Broadcast acted on after final byte
// - Broadcast delay is address times slot
// - Lower addresses reply earlier
// - Slot: 2.5 bytes plus jitter margin plus reply length
// - Address zero replies with no delay
// - 9600 baud 8N1 sets byte period
// - Reply leads with ACK or NAK
// - Address range 0 to 254, held here
module mrs_scheduler #(
  parameter logic [7:0] BCAST_ADDR = mrs_pkg::BCAST_ADDR_DEF,
  parameter int unsigned RESPONSE_CYC = mrs_pkg::RESP_CYC,
  parameter int unsigned JITTER_CYC = mrs_pkg::JITTER_CYC_DEF,
  parameter int unsigned REPLY_BYTES = mrs_pkg::REPLY_BYTES_DEF
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic clk_en,
  // Settings
  input wire mrs_pkg::mrs_link_e link_mode,
  input wire logic [7:0] unit_addr,
  input wire logic addr_load,
  // Received command, cmd_end pulses on the final byte
  input wire logic cmd_end,
  input wire mrs_pkg::mrs_cmd_s cmd,
  // Outcome
  output logic accept_q,
  output logic is_bcast_q,
  output mrs_pkg::mrs_reply_s reply_q,
  output logic [7:0] addr_q,
  output logic addr_err_q
);
  localparam int unsigned SLOT_CYC = RESPONSE_CYC + JITTER_CYC
    + REPLY_BYTES * mrs_pkg::CYC_PER_BYTE;

  function automatic logic multidrop(input mrs_pkg::mrs_link_e m);
    multidrop = (m == mrs_pkg::MRS_LINK_RS485_4W) || (m == mrs_pkg::MRS_LINK_RS485_2W);
  endfunction : multidrop

  logic [7:0] attn_q;
  logic timer_load;
  logic timer_busy;
  logic timer_done;
  logic [mrs_pkg::CNT_W-1:0] delay_cyc;
  logic hit_bcast;
  logic hit_own;
  logic bcast_now;
  logic [mrs_pkg::CNT_W-1:0] timer_count;
  logic [mrs_pkg::CNT_W-1:0] wait_cnt_q;
  logic [mrs_pkg::CNT_W-1:0] wait_goal_q;

  // Address setting; out-of-range values are refused and the old one kept
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      addr_q <= 8'h00;
      addr_err_q <= 1'b0;
    end
    else if (clk_en && addr_load)
    begin
      addr_err_q <= (unit_addr > mrs_pkg::ADDR_MAX);
      if (unit_addr <= mrs_pkg::ADDR_MAX)
      begin
        addr_q <= unit_addr;
      end
    end
  end

  assign hit_bcast = multidrop(link_mode) && (cmd.addr == BCAST_ADDR);
  assign hit_own = !multidrop(link_mode) || (cmd.addr == addr_q);
  // Slot count grows with address, so lower units always go first
  assign delay_cyc = mrs_pkg::CNT_W'(addr_q) * mrs_pkg::CNT_W'(SLOT_CYC);
  // Address zero skips the timer: its count of delay minus one would wrap to all ones
  assign bcast_now = hit_bcast && (delay_cyc == '0);
  // The reply flop adds a cycle after timer expiry, so the timer gets one less
  assign timer_count = delay_cyc - mrs_pkg::CNT_W'(1);
  assign timer_load = clk_en && cmd_end && hit_bcast && !bcast_now;

  // Decision on each completed command
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      accept_q <= 1'b0;
      is_bcast_q <= 1'b0;
      attn_q <= 8'h00;
    end
    else if (clk_en)
    begin
      accept_q <= cmd_end && (hit_bcast || hit_own);
      if (cmd_end)
      begin
        is_bcast_q <= hit_bcast;
      end
      // Only a broadcast parks its code, so a non-broadcast command cannot alter the parked code
      if (cmd_end && hit_bcast)
      begin
        attn_q <= cmd.ok ? mrs_pkg::ATTN_ACK : mrs_pkg::ATTN_NAK;
      end
    end
  end

  mrs_delay_timer #(
    .W(mrs_pkg::CNT_W)
  ) u_timer (
    .mclk(mclk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .load(timer_load),
    .count(timer_count),
    .abort(1'b0),
    .busy_q(timer_busy),
    .done_q(timer_done)
  );

  // Reply strobe: addressed hits at once, broadcasts after their slot
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      reply_q <= '0;
    end
    else if (clk_en)
    begin
      reply_q.go <= 1'b0;
      if (cmd_end && ((!hit_bcast && hit_own) || bcast_now))
      begin
        reply_q.go <= 1'b1;
        reply_q.attn <= cmd.ok ? mrs_pkg::ATTN_ACK : mrs_pkg::ATTN_NAK;
      end
      else if (timer_done)
      begin
        reply_q.go <= 1'b1;
        reply_q.attn <= attn_q;
      end
    end
  end

  // Enabled cycles since the last delayed broadcast was loaded, held once it reaches the slot goal; counted apart
  // from the timer so the slot checks below do not trust the timer's own count
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wait_cnt_q <= '0;
      wait_goal_q <= '0;
    end
    else if (clk_en)
    begin
      if (timer_load)
      begin
        wait_cnt_q <= mrs_pkg::CNT_W'(1);
        wait_goal_q <= delay_cyc;
      end
      else if (wait_cnt_q != '0 && wait_cnt_q != wait_goal_q)
      begin
        wait_cnt_q <= wait_cnt_q + mrs_pkg::CNT_W'(1);
      end
    end
  end

  // Assertions
  AST_SILENT_OTHER: assert property (@(posedge mclk) disable iff (!reset_n)
    (clk_en && cmd_end && multidrop(link_mode) && cmd.addr != addr_q && cmd.addr != BCAST_ADDR
      && !timer_busy && !timer_done)
    |=> !reply_q.go)
    else $error("reply sent for foreign address");
  AST_OWN_NOW: assert property (@(posedge mclk) disable iff (!reset_n)
    (clk_en && cmd_end && !hit_bcast && hit_own) |=> reply_q.go)
    else $error("addressed reply not immediate");
  AST_SINGLE_HOST: assert property (@(posedge mclk) disable iff (!reset_n)
    (clk_en && cmd_end && !multidrop(link_mode)) |=> accept_q && !is_bcast_q)
    else $error("point-to-point command filtered");
  AST_ZERO_NOW: assert property (@(posedge mclk) disable iff (!reset_n)
    (clk_en && cmd_end && hit_bcast && addr_q == 8'h00) |=> reply_q.go)
    else $error("address zero reply delayed");
  AST_HIGH_WAITS: assert property (@(posedge mclk) disable iff (!reset_n)
    (timer_load && delay_cyc >= mrs_pkg::CNT_W'(8)) |=> !reply_q.go [*8])
    else $error("higher address replied early");
  AST_ACK_CODE: assert property (@(posedge mclk) disable iff (!reset_n)
    reply_q.go |-> (reply_q.attn == mrs_pkg::ATTN_ACK || reply_q.attn == mrs_pkg::ATTN_NAK))
    else $error("bad reply lead byte");
  AST_ADDR_RANGE: assert property (@(posedge mclk) disable iff (!reset_n)
    addr_q <= mrs_pkg::ADDR_MAX)
    else $error("address out of range");
  AST_BCAST_ACCEPT: assert property (@(posedge mclk) disable iff (!reset_n)
    (clk_en && cmd_end && hit_bcast) |=> accept_q && is_bcast_q)
    else $error("broadcast not accepted");
  AST_MULTIDROP: assert property (@(posedge mclk) disable iff (!reset_n)
    (clk_en && cmd_end && multidrop(link_mode) && cmd.addr == addr_q) |=> accept_q)
    else $error("own address not accepted");
  AST_ACCEPT_CAUSE: assert property (@(posedge mclk) disable iff (!reset_n)
    $rose(accept_q) |-> $past(cmd_end))
    else $error("accept without a command");
  AST_ACCEPT_PULSE: assert property (@(posedge mclk) disable iff (!reset_n)
    (clk_en && !cmd_end) |=> !accept_q)
    else $error("accept held too long");
  AST_IDLE_SILENT: assert property (@(posedge mclk) disable iff (!reset_n)
    (clk_en && !cmd_end && !timer_done) |=> !reply_q.go)
    else $error("reply without cause");
  AST_FREEZE: assert property (@(posedge mclk) disable iff (!reset_n)
    !clk_en |=> $stable(reply_q) && $stable(accept_q) && $stable(addr_q))
    else $error("state moved while frozen");
  AST_SLOT_EXACT: assert property (@(posedge mclk) disable iff (!reset_n)
    (clk_en && timer_done) |-> wait_cnt_q == wait_goal_q)
    else $error("broadcast slot length wrong");
  AST_SLOT_NOT_EARLY: assert property (@(posedge mclk) disable iff (!reset_n)
    (wait_cnt_q != '0 && wait_cnt_q < wait_goal_q) |-> timer_busy && !timer_done)
    else $error("broadcast slot ended early");
  AST_ACK_NOW: assert property (@(posedge mclk) disable iff (!reset_n)
    (clk_en && cmd_end && !hit_bcast && hit_own && cmd.ok) |=> reply_q.attn == mrs_pkg::ATTN_ACK)
    else $error("good command not acknowledged");
  AST_NAK_NOW: assert property (@(posedge mclk) disable iff (!reset_n)
    (clk_en && cmd_end && !hit_bcast && hit_own && !cmd.ok) |=> reply_q.attn == mrs_pkg::ATTN_NAK)
    else $error("failed command not refused");
  AST_ERR_FLAG: assert property (@(posedge mclk) disable iff (!reset_n)
    (clk_en && addr_load && unit_addr > mrs_pkg::ADDR_MAX) |=> addr_err_q && $stable(addr_q))
    else $error("bad address not refused");
endmodule : mrs_scheduler

// file: verif/mrs_host_model.sv
`timescale 1ns/1ps
module mrs_host_model #(
  parameter int unsigned GUARD = mrs_pkg::GUARD_CYC,
  parameter int unsigned SLOT = 1,
  parameter int unsigned N_UNITS = 3
) (
  // Clock
  input wire logic mclk,
  // Command to unit
  output logic cmd_end,
  output mrs_pkg::mrs_cmd_s cmd
);
  int unsigned cyc = 0;
  int unsigned last = 0;
  int unsigned need = 0;
  initial
  begin
    cmd_end = 1'b0;
    cmd = '0;
  end
  always @(posedge mclk) cyc <= cyc + 1;
  task automatic send(input logic [7:0] a, input logic ok, input logic bc);
    while (cyc - last < need) @(negedge mclk);
    cmd_end = 1'b1;
    cmd.addr = a;
    cmd.ok = ok;
    @(negedge mclk);
    cmd_end = 1'b0;
    // A released line must not keep showing the old command
    cmd = mrs_pkg::mrs_cmd_s'(~cmd);
    last = cyc;
    need = bc ? N_UNITS * SLOT + GUARD : GUARD;
  endtask : send
endmodule : mrs_host_model

// file: verif/tb_multidrop_response_scheduler.sv
`timescale 1ns/1ps
module tb_multidrop_response_scheduler;
  // Shortened response time keeps a full slot walk within the run's cycle budget
  localparam int unsigned RESP_T = 100;
  localparam int unsigned JIT = 7;
  localparam int unsigned SLOT = RESP_T + JIT;
  logic clk_en = 1'b1;
  int unsigned seen;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] unit_addr = 8'h00;
  logic addr_load = 1'b0;
  mrs_pkg::mrs_link_e link_mode = mrs_pkg::MRS_LINK_RS232;
  logic cmd_end;
  mrs_pkg::mrs_cmd_s cmd;
  logic accept_q, is_bcast_q, addr_err_q;
  logic [7:0] addr_q;
  mrs_pkg::mrs_reply_s reply_q;
  int error_cnt = 0;
  int total_checks = 0;
  int unsigned n;
  always #12.5 mclk = ~mclk;
  mrs_host_model #(.GUARD(40), .SLOT(SLOT)) host (.mclk(mclk), .cmd_end(cmd_end), .cmd(cmd));
  mrs_scheduler #(.RESPONSE_CYC(RESP_T), .JITTER_CYC(JIT), .REPLY_BYTES(0)) dut (.mclk(mclk), .reset_n(reset_n),
    .clk_en(clk_en), .link_mode(link_mode), .unit_addr(unit_addr), .addr_load(addr_load), .cmd_end(cmd_end),
    .cmd(cmd),
    .accept_q(accept_q), .is_bcast_q(is_bcast_q), .reply_q(reply_q), .addr_q(addr_q), .addr_err_q(addr_err_q));
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : results
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic load(input logic [7:0] a);
    unit_addr = a;
    addr_load = 1'b1;
    @(negedge mclk);
    addr_load = 1'b0;
    @(negedge mclk);
  endtask : load
  task automatic t_p2p();
    for (int m = 0; m < 2; m++)
    begin
      link_mode = mrs_pkg::mrs_link_e'(m);
      host.send(8'hff, m[0], 1'b0);
      chk("accept", 1, accept_q);
      chk("no_bcast", 0, is_bcast_q);
      chk("go", 1, reply_q.go);
      chk("attn", m ? 8'h06 : 8'h15, reply_q.attn);
    end
    $display("test p2p done");
  endtask : t_p2p
  task automatic t_addr();
    link_mode = mrs_pkg::MRS_LINK_RS485_4W;
    load(8'h05);
    chk("addr", 8'h05, addr_q);
    load(8'hff);
    chk("addr_err", 1, addr_err_q);
    chk("addr_kept", 8'h05, addr_q);
    load(8'hfe);
    chk("addr_top", 8'hfe, addr_q);
    chk("addr_err_clr", 0, addr_err_q);
    load(8'h05);
    host.send(8'h06, 1'b1, 1'b0);
    chk("accept_other", 0, accept_q);
    chk("go_other", 0, reply_q.go);
    host.send(8'h05, 1'b1, 1'b0);
    chk("accept_own", 1, accept_q);
    chk("go_own", 1, reply_q.go);
    chk("attn_own", 8'h06, reply_q.attn);
    $display("test addr done");
  endtask : t_addr
  // Counts falling edges in n until the reply strobe shows; a spent bound ends the run
  task automatic wait_go(input int unsigned lim);
    while (reply_q.go !== 1'b1 && n < lim)
    begin
      @(negedge mclk);
      n++;
    end
    if (reply_q.go !== 1'b1)
    begin
      error_cnt++;
      $display("BAD reply_go exp 1 got 0");
      results();
    end
  endtask : wait_go
  task automatic t_bcast(input logic [7:0] a, input logic ok);
    link_mode = mrs_pkg::MRS_LINK_RS485_2W;
    load(a);
    host.send(8'hff, ok, 1'b1);
    chk("accept_bc", 1, accept_q);
    chk("is_bcast", 1, is_bcast_q);
    n = 1;
    wait_go(2000);
    // Lower addresses wait fewer slots, so ordering follows from exact delay
    chk("bc_delay", 1 + a * SLOT, n);
    chk("bc_attn", ok ? 8'h06 : 8'h15, reply_q.attn);
    @(negedge mclk);
    chk("bc_go_once", 0, reply_q.go);
    $display("test bcast done");
  endtask : t_bcast
  task automatic t_freeze();
    link_mode = mrs_pkg::MRS_LINK_RS485_4W;
    load(8'h01);
    host.send(8'hff, 1'b0, 1'b1);
    n = 1;
    repeat (5)
    begin
      @(negedge mclk);
      n++;
    end
    clk_en = 1'b0;
    repeat (20)
    begin
      @(negedge mclk);
      n++;
    end
    clk_en = 1'b1;
    wait_go(2000);
    chk("freeze_delay", 1 + SLOT + 20, n);
    chk("freeze_attn", 8'h15, reply_q.attn);
    $display("test freeze done");
  endtask : t_freeze
  task automatic t_reset();
    link_mode = mrs_pkg::MRS_LINK_RS485_2W;
    load(8'h01);
    load(8'hff);
    host.send(8'hff, 1'b1, 1'b1);
    repeat (10) @(negedge mclk);
    reset_n = 1'b0;
    repeat (3) @(negedge mclk);
    reset_n = 1'b1;
    chk("addr_reset", 8'h00, addr_q);
    chk("err_reset", 0, addr_err_q);
    seen = 0;
    repeat (SLOT + 10)
    begin
      @(negedge mclk);
      if (reply_q.go !== 1'b0)
        seen++;
    end
    chk("go_after_reset", 0, seen);
    $display("test reset done");
  endtask : t_reset
  initial
  begin
    repeat (16) @(negedge mclk);
    reset_n = 1'b1;
    @(negedge mclk);
    t_p2p();
    t_addr();
    t_bcast(8'h00, 1'b1);
    t_bcast(8'h02, 1'b0);
    t_freeze();
    t_reset();
    results();
  end
endmodule : tb_multidrop_response_scheduler
